//--- pic_pkg.sv
// Purpose: shared constants and types of the priority interrupt controller
// Assumes: 8-bit register data on a 32-bit classic wishbone bus
// Notes: register indices are word indices, byte address is four times the index
package pic_pkg;
  localparam int PIC_NSRC = 8;
  localparam logic [11:0] PIC_IDX_REQ = 12'hFC0;
  localparam logic [11:0] PIC_IDX_ENH = 12'hFC1;
  localparam logic [11:0] PIC_IDX_ENL = 12'hFC2;
  localparam logic [11:0] PIC_IDX_CTL = 12'hFCF;
  localparam logic [11:0] PIC_IDX_STAT = 12'hFD0;
  localparam logic [11:0] PIC_IDX_MASK = 12'hFD1;
  localparam logic [7:0] PIC_RST_BYTE = 8'h00;
  localparam int PIC_GATE_BIT = 7;
  localparam logic [1:0] PIC_LVL_OFF = 2'h0;
  localparam logic [1:0] PIC_LVL_1 = 2'h1;
  localparam logic [1:0] PIC_LVL_2 = 2'h2;
  localparam logic [1:0] PIC_LVL_3 = 2'h3;
  // sticky event bits of the status register
  localparam int PIC_EV_TAKEN = 0;
  localparam int PIC_EV_OVERRUN = 1;
  localparam int PIC_EV_SPECIAL = 2;
  localparam int PIC_NEV = 3;
  // source 7 is timer 2 ... source 0 is the converter
  localparam logic [2:0] PIC_VEC_SPECIAL = 3'h7;

  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_PRESENT = 2'b01,
    PIC_SPECIAL = 2'b11
  } pic_state_t;

  typedef struct packed {
    logic valid;
    logic special;
    logic [2:0] vector;
    logic [1:0] level;
  } pic_req_t;

  typedef struct packed {
    logic unmask_all;
    logic mask_all;
    logic ret;
    logic ack;
  } pic_cpu_t;
endpackage

//--- pic_arbiter.sv
// Purpose: picks the winning pending source by level, then by fixed order
// Assumes: raw pending bits; sources at the off level are gated out here
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module pic_arbiter import pic_pkg::*; (
  input wire logic [7:0] pend_i,
  input wire logic [7:0] enh_i,
  input wire logic [7:0] enl_i,
  output logic found_o,
  output logic [2:0] vec_o,
  output logic [1:0] lvl_o
);
  always_comb begin
    found_o = 1'b0;
    vec_o = 3'h0;
    lvl_o = PIC_LVL_OFF;
    // higher index wins inside a level, so scan upward and let later hits replace
    for (int i = 0; i < PIC_NSRC; i++) begin
      if (pend_i[i] && {enh_i[i], enl_i[i]} != PIC_LVL_OFF) begin
        if (!found_o || {enh_i[i], enl_i[i]} >= lvl_o) begin
          found_o = 1'b1;
          vec_o = 3'(i);
          lvl_o = {enh_i[i], enl_i[i]};
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- pic_top.sv
// Purpose: priority interrupt controller for an 8-bit core, wishbone register access
// Assumes: peripheral requests are one-cycle pulses on clk_i
// Notes: one-cycle ack latency on the bus
// Function
// - unmask-all, return-from-handler or writing 1 sets the global gate
// - mask-all, cpu acknowledge, writing 0 or reset clears the global gate
// - level 3 beats level 2, level 2 beats level 1
// - fixed per-source order decides among equal levels
// - reset, enabled watchdog and illegal-instruction trap beat all sources
// - one-cycle peripheral pulses are latched into request bits
// - cpu acknowledge clears the request until a new pulse
// - writing 0 to a request bit clears it
// - writing 1 to a request bit raises it; acknowledge clears it
// - enable pair decodes 00 off, 01 level 1, 10 level 2, 11 level 3
// - high enable bits 7..0: timer2, timer1, timer0, rx, tx, twowire, syncserial, converter
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pic_top import pic_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [13:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic [7:0] periph_pulse_i,
  input wire logic watchdog_irq_i,
  input wire logic watchdog_en_i,
  input wire logic illegal_trap_i,
  input wire pic_cpu_t cpu_i,
  output pic_req_t req_o,
  output logic irq_o
);
  // register state
  logic [7:0] request_group0, next_request_group0;
  logic [7:0] group0_priority_high_bits, next_group0_priority_high_bits;
  logic [7:0] group0_priority_low_bits, next_group0_priority_low_bits;
  logic global_interrupt_gate, next_global_interrupt_gate;
  logic [PIC_NEV-1:0] ev_stat, next_ev_stat;
  logic [PIC_NEV-1:0] ev_mask, next_ev_mask;
  logic [31:0] next_dat;
  logic next_ack, next_err;
  // presentation state
  pic_state_t state, next_state;
  pic_req_t pres, next_pres;
  logic special_pend, next_special_pend;

  logic found;
  logic [2:0] win_vec;
  logic [1:0] win_lvl;
  logic [PIC_NEV-1:0] ev;

  function automatic logic lane0_write(input logic [11:0] idx);
    lane0_write = cyc_i && stb_i && !ack_o && !err_o && we_i && sel_i[0] && adr_i[13:2] == idx;
  endfunction

  pic_arbiter u_arb (
    .pend_i(request_group0),
    .enh_i(group0_priority_high_bits),
    .enl_i(group0_priority_low_bits),
    .found_o(found),
    .vec_o(win_vec),
    .lvl_o(win_lvl)
  );

  // bus side and register file
  always_comb begin
    logic access;
    access = cyc_i && stb_i && !ack_o && !err_o;
    next_ack = 1'b0;
    next_err = 1'b0;
    next_dat = '0;
    next_group0_priority_high_bits = group0_priority_high_bits;
    next_group0_priority_low_bits = group0_priority_low_bits;
    next_ev_mask = ev_mask;
    if (access) begin
      if (adr_i[13:2] == PIC_IDX_REQ) begin
        next_ack = 1'b1;
        next_dat = {24'h000000, request_group0};
      end else if (adr_i[13:2] == PIC_IDX_ENH) begin
        next_ack = 1'b1;
        next_dat = {24'h000000, group0_priority_high_bits};
      end else if (adr_i[13:2] == PIC_IDX_ENL) begin
        next_ack = 1'b1;
        next_dat = {24'h000000, group0_priority_low_bits};
      end else if (adr_i[13:2] == PIC_IDX_CTL) begin
        next_ack = 1'b1;
        next_dat = 32'(global_interrupt_gate) << PIC_GATE_BIT;
      end else if (adr_i[13:2] == PIC_IDX_STAT) begin
        next_ack = 1'b1;
        next_dat = 32'(ev_stat);
      end else if (adr_i[13:2] == PIC_IDX_MASK) begin
        next_ack = 1'b1;
        next_dat = 32'(ev_mask);
      end else begin
        next_err = 1'b1;
      end
    end
    if (!we_i) begin
      next_dat = next_dat;
    end else begin
      next_dat = '0;
    end
    if (lane0_write(PIC_IDX_ENH)) begin
      next_group0_priority_high_bits = dat_i[7:0];
    end
    if (lane0_write(PIC_IDX_ENL)) begin
      next_group0_priority_low_bits = dat_i[7:0];
    end
    if (lane0_write(PIC_IDX_MASK)) begin
      next_ev_mask = dat_i[PIC_NEV-1:0];
    end
  end

  // request bits, gate and sticky status
  always_comb begin
    logic [7:0] clr;
    clr = '0;
    next_request_group0 = request_group0;
    next_global_interrupt_gate = global_interrupt_gate;
    ev = '0;
    if (lane0_write(PIC_IDX_REQ)) begin
      next_request_group0 = dat_i[7:0];
    end
    if (cpu_i.ack && state == PIC_PRESENT) begin
      clr[pres.vector] = 1'b1;
    end
    next_request_group0 = next_request_group0 & ~clr;
    // a pulse in the same cycle as a clear still lands
    next_request_group0 = next_request_group0 | periph_pulse_i;
    ev[PIC_EV_OVERRUN] = |(periph_pulse_i & request_group0);
    if (lane0_write(PIC_IDX_CTL)) begin
      next_global_interrupt_gate = dat_i[PIC_GATE_BIT];
    end
    if (cpu_i.unmask_all || cpu_i.ret) begin
      next_global_interrupt_gate = 1'b1;
    end
    // mask-all and acknowledge override, so a handler always starts masked
    if (cpu_i.mask_all || (cpu_i.ack && state != PIC_IDLE)) begin
      next_global_interrupt_gate = 1'b0;
      ev[PIC_EV_TAKEN] = cpu_i.ack;
    end
    ev[PIC_EV_SPECIAL] = illegal_trap_i || (watchdog_irq_i && watchdog_en_i);
    next_ev_stat = ev_stat;
    if (lane0_write(PIC_IDX_STAT)) begin
      next_ev_stat = ev_stat & ~dat_i[PIC_NEV-1:0];
    end
    next_ev_stat = next_ev_stat | ev;
  end

  // presentation to the cpu
  always_comb begin
    next_state = state;
    next_pres = pres;
    next_special_pend = special_pend;
    if (illegal_trap_i || (watchdog_irq_i && watchdog_en_i)) begin
      next_special_pend = 1'b1;
    end
    case (state)
      PIC_IDLE: begin
        if (next_special_pend) begin
          next_state = PIC_SPECIAL;
          next_pres = '{valid: 1'b1, special: 1'b1, vector: PIC_VEC_SPECIAL, level: PIC_LVL_3};
        end else if (global_interrupt_gate && found) begin
          next_state = PIC_PRESENT;
          next_pres = '{valid: 1'b1, special: 1'b0, vector: win_vec, level: win_lvl};
        end else begin
          next_pres = '0;
        end
      end
      PIC_PRESENT: begin
        if (cpu_i.ack) begin
          next_state = PIC_IDLE;
          next_pres = '0;
        end else if (special_pend) begin
          next_state = PIC_SPECIAL;
          next_pres = '{valid: 1'b1, special: 1'b1, vector: PIC_VEC_SPECIAL, level: PIC_LVL_3};
        end else if (!request_group0[pres.vector]) begin
          // withdrawn by software before the cpu took it
          next_state = PIC_IDLE;
          next_pres = '0;
        end
      end
      PIC_SPECIAL: begin
        if (cpu_i.ack) begin
          next_state = PIC_IDLE;
          next_pres = '0;
          next_special_pend = 1'b0;
        end
      end
      default: begin
        next_state = PIC_IDLE;
        next_pres = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      request_group0 <= PIC_RST_BYTE;
      group0_priority_high_bits <= PIC_RST_BYTE;
      group0_priority_low_bits <= PIC_RST_BYTE;
      global_interrupt_gate <= 1'b0;
      ev_stat <= '0;
      ev_mask <= '0;
      dat_o <= '0;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      state <= PIC_IDLE;
      pres <= '0;
      special_pend <= 1'b0;
    end else begin
      request_group0 <= next_request_group0;
      group0_priority_high_bits <= next_group0_priority_high_bits;
      group0_priority_low_bits <= next_group0_priority_low_bits;
      global_interrupt_gate <= next_global_interrupt_gate;
      ev_stat <= next_ev_stat;
      ev_mask <= next_ev_mask;
      dat_o <= next_dat;
      ack_o <= next_ack;
      err_o <= next_err;
      state <= next_state;
      pres <= next_pres;
      special_pend <= next_special_pend;
    end
  end

  assign req_o = pres;
  assign irq_o = |(ev_stat & ev_mask);
endmodule
`default_nettype wire

//--- pic_top_sva.sv
// Purpose: port checks of the interrupt controller
// Assumes: one clock, sync reset
// Notes: bound to pic_top
`timescale 1ns/1ps
`default_nettype none
module pic_top_sva import pic_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [13:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [7:0] periph_pulse_i,
  input wire logic watchdog_irq_i,
  input wire logic watchdog_en_i,
  input wire logic illegal_trap_i,
  input wire pic_cpu_t cpu_i,
  input wire pic_req_t req_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic spec_in;
  assign spec_in = illegal_trap_i | (watchdog_irq_i & watchdog_en_i);
  a_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
    else $error("bus access not answered");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_err_quiet: assert property (err_o |-> !ack_o && dat_o == 32'h0)
    else $error("error with data or ack");
  a_ack_clears: assert property (cpu_i.ack && req_o.valid && !req_o.special |=> !req_o.valid || req_o.special)
    else $error("request kept after cpu ack");
  // bus writes and special pulses may legally move the request
  a_req_hold: assert property (req_o.valid && !cpu_i.ack && !(cyc_i && stb_i) && !$past(ack_o)
    && !spec_in && !$past(spec_in) |=> $stable(req_o))
    else $error("presented request changed");
  a_special_form: assert property (req_o.special |-> req_o.valid && req_o.vector == PIC_VEC_SPECIAL
    && req_o.level == PIC_LVL_3)
    else $error("special request malformed");
  a_special_wins: assert property (spec_in && !req_o.special |-> ##[1:3] req_o.special)
    else $error("special not presented");
  a_level_on: assert property (req_o.valid |-> req_o.level != PIC_LVL_OFF)
    else $error("request presented at disabled level");
endmodule
bind pic_top pic_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .periph_pulse_i(periph_pulse_i), .watchdog_irq_i(watchdog_irq_i), .watchdog_en_i(watchdog_en_i),
  .illegal_trap_i(illegal_trap_i), .cpu_i(cpu_i), .req_o(req_o), .irq_o(irq_o));
`default_nettype wire

//--- pic_cpu_model.sv
// Purpose: core side that takes and returns from interrupts
// Assumes: request level held until ack
// Notes: ack after dly_i+1 cycles, return two cycles later
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model import pic_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pic_req_t req_i,
  input wire logic [3:0] dly_i,
  input wire logic mask_i,
  output pic_cpu_t cpu_o
);
  logic [3:0] cnt;
  logic [1:0] ret_cnt;
  always_ff @(posedge clk_i) begin
    cpu_o <= '0;
    cpu_o.mask_all <= mask_i & ~rst_i;
    cnt <= '0;
    ret_cnt <= (ret_cnt != 2'h0) ? ret_cnt - 2'h1 : 2'h0;
    cpu_o.ret <= (ret_cnt == 2'h1) & ~rst_i;
    if (rst_i) begin
      ret_cnt <= 2'h0;
    end else if (req_i.valid && !cpu_o.ack) begin
      // slow handlers keep the request standing for a while
      cnt <= cnt + 4'h1;
      if (cnt >= dly_i) begin
        cpu_o.ack <= 1'b1;
        cnt <= '0;
        ret_cnt <= 2'h2;
      end
    end
  end
endmodule
`default_nettype wire

//--- pic_top_tb.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: one-cycle bus answer
// Notes: records every acknowledged request
`timescale 1ns/1ps
`default_nettype none
module pic_top_tb;
  import pic_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, wden = 0, mask = 0, berr;
  logic [13:0] adr_i = '0;
  logic [31:0] dat_i = '0, rd;
  logic [9:0] pv = '0;
  logic [3:0] dly = '0;
  wire logic [31:0] dat_o;
  wire logic ack_o, err_o, irq_o;
  wire pic_req_t req_o;
  wire pic_cpu_t cpu_i;
  int bad_count = 0, compares = 0;
  pic_req_t taken[$];
  always #12.5 clk_i = ~clk_i;
  pic_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(4'hF),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .periph_pulse_i(pv[7:0]),
    .watchdog_irq_i(pv[8]), .watchdog_en_i(wden), .illegal_trap_i(pv[9]), .cpu_i(cpu_i), .req_o(req_o),
    .irq_o(irq_o));
  pic_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_o), .dly_i(dly), .mask_i(mask), .cpu_o(cpu_i));
  always @(posedge clk_i) if (cpu_i.ack === 1'b1 && req_o.valid === 1'b1) taken.push_back(req_o);
  task complete_run;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, idx, 2'b00, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    {rd, berr} = {dat_o, err_o};
    {cyc_i, stb_i} <= 2'b00;
    if (n >= 20) begin
      bad_count++;
      $display("[ERR] %0t bus access not answered", $time);
      complete_run();
    end
  endtask
  task pulse(input logic [9:0] p);
    @(posedge clk_i);
    pv <= p;
    @(posedge clk_i);
    pv <= '0;
  endtask
  task wait_n(input int k);
    int n;
    for (n = 0; n < 300 && taken.size() < k; n++) @(posedge clk_i);
    if (taken.size() < k) begin
      bad_count++;
      complete_run();
    end
  endtask
  task t_reset;
    logic [11:0] ix [6] = '{PIC_IDX_REQ, PIC_IDX_ENH, PIC_IDX_ENL, PIC_IDX_CTL, PIC_IDX_STAT, PIC_IDX_MASK};
    foreach (ix[i]) begin
      wb(0, ix[i], 8'h00);
      chk(rd[7:0], PIC_RST_BYTE);
    end
    wb(0, 12'h000, 8'h00);
    chk({7'h0, berr}, 8'h01);
    wb(1, PIC_IDX_CTL, 8'h80);
    wb(0, PIC_IDX_CTL, 8'h00);
    chk(rd[7:0], 8'h80);
    @(posedge clk_i) mask <= 1;
    @(posedge clk_i) mask <= 0;
    wb(0, PIC_IDX_CTL, 8'h00);
    chk(rd[7:0], 8'h00);
    $display("test reset done");
  endtask
  task t_levels;
    for (int c = 0; c < 4; c++) begin
      taken.delete();
      wb(1, PIC_IDX_ENH, {2'b00, c[1], 5'h00});
      wb(1, PIC_IDX_ENL, {2'b00, c[0], 5'h00});
      wb(1, PIC_IDX_CTL, 8'h80);
      pulse(10'h020);
      repeat (12) @(posedge clk_i);
      chk(taken.size(), (c != 0));
      if (c != 0) chk({taken[0].vector, taken[0].level}, {3'h5, c[1:0]});
      wb(0, PIC_IDX_REQ, 8'h00);
      chk(rd[7:0], (c == 0) ? 8'h20 : 8'h00);
      wb(1, PIC_IDX_REQ, 8'h00);
      wb(0, PIC_IDX_REQ, 8'h00);
      chk(rd[7:0], 8'h00);
    end
    $display("test levels done");
  endtask
  task t_prio;
    logic [4:0] exp [4] = '{{3'h2, PIC_LVL_3}, {3'h7, PIC_LVL_2}, {3'h6, PIC_LVL_2}, {3'h1, PIC_LVL_1}};
    taken.delete();
    dly <= 4'h3;
    wb(1, PIC_IDX_ENH, 8'hC4);
    wb(1, PIC_IDX_ENL, 8'h06);
    wb(1, PIC_IDX_REQ, 8'hC6);
    wb(1, PIC_IDX_CTL, 8'h80);
    wait_n(4);
    foreach (exp[i]) chk({taken[i].vector, taken[i].level}, exp[i]);
    $display("test priority done");
  endtask
  task t_special;
    taken.delete();
    dly <= 4'h8;
    wb(1, PIC_IDX_MASK, 8'h07);
    wb(1, PIC_IDX_ENH, 8'h01);
    wb(1, PIC_IDX_ENL, 8'h00);
    wb(1, PIC_IDX_CTL, 8'h80);
    pulse(10'h001);
    repeat (3) @(posedge clk_i);
    pulse(10'h200);
    wait_n(2);
    chk({taken[0].special, taken[1].vector}, 4'h8);
    wden <= 1;
    pulse(10'h100);
    wait_n(3);
    chk(taken[2].special, 1'b1);
    repeat (4) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(1, PIC_IDX_STAT, 8'hFF);
    wb(0, PIC_IDX_STAT, 8'h00);
    chk(rd[7:0], 8'h00);
    chk({7'h0, irq_o}, 8'h00);
    $display("test special done");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_levels();
    t_prio();
    t_special();
    complete_run();
  end
endmodule
`default_nettype wire
